//--- verilog/pll_fbdiv_defs.vh
// Register offsets, field positions, reset values and codes of the feedback/status block
`ifndef PLL_FBDIV_DEFS_VH
`define PLL_FBDIV_DEFS_VH

// Register offsets
`define R_LSB_ADDR        10'h011
`define R_MSB_ADDR        10'h012
`define SWALLOW_ADDR      10'h013
`define MAIN_LSB_ADDR     10'h014
`define MAIN_MSB_ADDR     10'h015
`define FBCTRL_ADDR       10'h016
`define STATUS_SEL_ADDR   10'h017
`define EEPROM_CTRL_ADDR  10'h01d

// Field positions
`define PRESC_MSB         2
`define PRESC_LSB         0
`define MAIN_BYPASS_BIT   3
`define RESET_ALL_BIT     4
`define RESET_AB_BIT      5
`define RESET_R_BIT       6
`define SEL_MSB           7
`define SEL_LSB           2
`define EEPROM_LOCK_BIT   7

// Reset values
`define R_LSB_RST         8'h01
`define R_MSB_RST         8'h00
`define SWALLOW_RST       8'h00
`define MAIN_LSB_RST      8'h03
`define MAIN_MSB_RST      8'h00
`define FBCTRL_RST        8'h06
`define STATUS_SEL_RST    8'h00
`define EEPROM_CTRL_RST   8'h00

// Prescaler mode codes
`define PRESC_FIX1        3'h0
`define PRESC_FIX2        3'h1
`define PRESC_DUAL2       3'h2
`define PRESC_DUAL4       3'h3
`define PRESC_DUAL8       3'h4
`define PRESC_DUAL16      3'h5
`define PRESC_DUAL32      3'h6
`define PRESC_FIX3        3'h7

// Status selector codes
`define SEL_GROUND        6'h00
`define SEL_NDIV          6'h01
`define SEL_RDIV          6'h02
`define SEL_SWALLOW       6'h03
`define SEL_PRESC         6'h04
`define SEL_PD_UP         6'h05
`define SEL_PD_DOWN       6'h06
`define SEL_GROUND_HI     6'h20
`define SEL_FIRST_REF     6'h21
`define SEL_SECOND_REF    6'h22
`define SEL_REF_SELECTED  6'h23
`define SEL_REF_UNSEL     6'h24

`endif

//--- verilog/pll_prescaler_and_status_select.v
// Feedback prescaler, swallow/main counters, reference divider and status pin selectors
//
// Summary of operation
// - Three-bit prescaler mode; fixed divide one, two, three
// - Code 010: divide two/three, two if swallow zero
// - Code 011: divide four/five, four if swallow zero
// - Code 100: divide eight/nine, eight if swallow zero
// - Code 101: divide sixteen/seventeen, sixteen if zero
// - Code 110 default: thirty-two/thirty-three dual modulus
// - Selector 000000 ground default; 000001 delayed feedback
// - Codes 000010-000110: reference, swallow, prescaler, up, down
// - Unassigned low-half selector codes drive ground
// - High-half codes shared by monitor and lock pins
// - 100000 ground; 100001 first or differential reference
// - 100010 second reference; then selected, unselected reference
// - Selected reference is differential one in differential mode
// - Main counter bypass only in fixed divide modes
`timescale 1ns/1ps
`include "pll_fbdiv_defs.vh"

module pll_prescaler_and_status_select #(
	parameter ADDR_W = 10,
	parameter DATA_W = 8
) (
	input  wire              clk_in,
	input  wire              rst_b_in,
	input  wire              ce_in,
	input  wire [ADDR_W-1:0] reg_addr_in,
	input  wire [DATA_W-1:0] reg_wdata_in,
	input  wire              reg_wr_in,
	output reg  [DATA_W-1:0] reg_rdata_out,
	input  wire              vco_clk_in,
	input  wire              first_reference_clock_in,
	input  wire              second_reference_clock_in,
	input  wire              diff_ref_mode_in,
	input  wire              second_ref_selected_in,
	input  wire              phase_detector_up_in,
	input  wire              phase_detector_down_in,
	input  wire [4:0]        reference_monitor_sel_in,
	input  wire [4:0]        lock_detect_sel_in,
	output reg               feedback_out,
	output reg               status_pin_out,
	output reg               reference_monitor_pin_out,
	output reg               lock_detect_pin_out
);

	//********************************************************************
	// Functions
	//********************************************************************

	// Base modulus of the prescaler for a mode code
	function [5:0] presc_base;
		input [2:0] mode;
		begin
			case (mode)
				`PRESC_FIX1:   presc_base = 6'h01;
				`PRESC_FIX2:   presc_base = 6'h02;
				`PRESC_FIX3:   presc_base = 6'h03;
				`PRESC_DUAL2:  presc_base = 6'h02;
				`PRESC_DUAL4:  presc_base = 6'h04;
				`PRESC_DUAL8:  presc_base = 6'h08;
				`PRESC_DUAL16: presc_base = 6'h10;
				`PRESC_DUAL32: presc_base = 6'h20;
				default:     presc_base = 6'h01;
			endcase
		end
	endfunction
	// Fixed-divide codes; every other code is dual modulus
	function is_fixed;
		input [2:0] mode;
		begin
			is_fixed = (mode == `PRESC_FIX1) || (mode == `PRESC_FIX2) || (mode == `PRESC_FIX3);
		end
	endfunction
	// Signal picked by a selector code; shared by all three pins
	function sel_bit;
		input [5:0] code;
		input       n_dly;
		input       r_dly;
		input       swl;
		input       pres;
		input       up;
		input       dn;
		input       ref_a;
		input       ref_b;
		input       ref_b_sel;
		input       diff;
		begin
			case (code)
				`SEL_GROUND:       sel_bit = 1'b0;
				`SEL_NDIV:         sel_bit = n_dly;
				`SEL_RDIV:         sel_bit = r_dly;
				`SEL_SWALLOW:      sel_bit = swl;
				`SEL_PRESC:        sel_bit = pres;
				`SEL_PD_UP:        sel_bit = up;
				`SEL_PD_DOWN:      sel_bit = dn;
				`SEL_GROUND_HI:    sel_bit = 1'b0;
				`SEL_FIRST_REF:    sel_bit = ref_a;
				`SEL_SECOND_REF:   sel_bit = diff ? 1'b0 : ref_b;
				`SEL_REF_SELECTED: sel_bit = (diff || !ref_b_sel) ? ref_a : ref_b;
				`SEL_REF_UNSEL:    sel_bit = diff ? 1'b0 : (ref_b_sel ? ref_a : ref_b);
				default:           sel_bit = 1'b0;
			endcase
		end
	endfunction

	//********************************************************************
	// Registers
	//********************************************************************

	reg  [7:0]  r_lsb;
	reg  [7:0]  r_msb;
	reg  [7:0]  swallow_byte;
	reg  [7:0]  main_lsb;
	reg  [7:0]  main_msb;
	reg  [7:0]  fbctrl;
	reg  [7:0]  status_pin_select;
	reg  [7:0]  eeprom_ctrl;
	wire [2:0]  feedback_prescaler_mode;
	wire [13:0] r_count;
	wire [5:0]  swallow_count;
	wire [12:0] main_count;
	wire [5:0]  status_code;
	wire        hold_r;
	wire        hold_ab;
	assign feedback_prescaler_mode = fbctrl[`PRESC_MSB:`PRESC_LSB];
	assign r_count                 = {r_msb[5:0], r_lsb};
	assign swallow_count           = swallow_byte[5:0];
	assign main_count              = {main_msb[4:0], main_lsb};
	assign status_code             = status_pin_select[`SEL_MSB:`SEL_LSB];
	assign hold_r                  = fbctrl[`RESET_R_BIT] | fbctrl[`RESET_ALL_BIT];
	assign hold_ab                 = fbctrl[`RESET_AB_BIT] | fbctrl[`RESET_ALL_BIT];

	// Register writes; the selector is protected while the lock bit is set
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			r_lsb             <= `R_LSB_RST;
			r_msb             <= `R_MSB_RST;
			swallow_byte      <= `SWALLOW_RST;
			main_lsb          <= `MAIN_LSB_RST;
			main_msb          <= `MAIN_MSB_RST;
			fbctrl            <= `FBCTRL_RST;
			status_pin_select <= `STATUS_SEL_RST;
			eeprom_ctrl       <= `EEPROM_CTRL_RST;
		end else if (ce_in && reg_wr_in) begin
			case (reg_addr_in)
				`R_LSB_ADDR:       r_lsb       <= reg_wdata_in;
				`R_MSB_ADDR:       r_msb       <= {2'h0, reg_wdata_in[5:0]};
				`SWALLOW_ADDR:     swallow_byte <= {2'h0, reg_wdata_in[5:0]};
				`MAIN_LSB_ADDR:    main_lsb    <= reg_wdata_in;
				`MAIN_MSB_ADDR:    main_msb    <= {3'h0, reg_wdata_in[4:0]};
				`FBCTRL_ADDR:      fbctrl      <= reg_wdata_in;
				`STATUS_SEL_ADDR: begin
					if (!eeprom_ctrl[`EEPROM_LOCK_BIT])
						status_pin_select <= reg_wdata_in;
				end
				`EEPROM_CTRL_ADDR: eeprom_ctrl <= reg_wdata_in;
				default: ;
			endcase
		end
	end

	// Read data one cycle after the address; unmapped reads return zero
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= 8'h00;
		end else if (ce_in) begin
			case (reg_addr_in)
				`R_LSB_ADDR:       reg_rdata_out <= r_lsb;
				`R_MSB_ADDR:       reg_rdata_out <= r_msb;
				`SWALLOW_ADDR:     reg_rdata_out <= swallow_byte;
				`MAIN_LSB_ADDR:    reg_rdata_out <= main_lsb;
				`MAIN_MSB_ADDR:    reg_rdata_out <= main_msb;
				`FBCTRL_ADDR:      reg_rdata_out <= fbctrl;
				`STATUS_SEL_ADDR:  reg_rdata_out <= status_pin_select;
				`EEPROM_CTRL_ADDR: reg_rdata_out <= eeprom_ctrl;
				default:           reg_rdata_out <= 8'h00;
			endcase
		end
	end

	//********************************************************************
	// Input synchronisers
	//********************************************************************
	// Pins are asynchronous; the model only works for clocks well below clk_in / 2
	reg  [2:0] vco_sync;
	reg  [2:0] first_ref_sync;
	reg  [2:0] second_ref_sync;

	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			vco_sync        <= 3'h0;
			first_ref_sync  <= 3'h0;
			second_ref_sync <= 3'h0;
		end else if (ce_in) begin
			vco_sync        <= {vco_sync[1:0], vco_clk_in};
			first_ref_sync  <= {first_ref_sync[1:0], first_reference_clock_in};
			second_ref_sync <= {second_ref_sync[1:0], second_reference_clock_in};
		end
	end
	wire vco_rise;
	wire ref_rise;
	wire use_first_ref;
	wire sel_ref_now;
	wire sel_ref_old;
	assign vco_rise      = vco_sync[1] & ~vco_sync[2];
	assign use_first_ref = diff_ref_mode_in || !second_ref_selected_in;
	assign sel_ref_now   = use_first_ref ? first_ref_sync[1] : second_ref_sync[1];
	assign sel_ref_old   = use_first_ref ? first_ref_sync[2] : second_ref_sync[2];
	assign ref_rise    = sel_ref_now & ~sel_ref_old;

	//********************************************************************
	// Feedback divider
	//********************************************************************

	reg  [5:0]  presc_cnt;
	reg  [12:0] cycle_cnt;
	reg  [5:0]  swallowed;
	reg         presc_pulse;
	reg         swallow_pulse;
	reg         n_pulse;
	reg         n_delayed;
	wire        fixed_mode;
	wire        use_large;
	wire [5:0]  modulus;
	wire [12:0] main_eff;
	wire        presc_done;
	wire        period_done;
	assign fixed_mode  = is_fixed(feedback_prescaler_mode);
	// Larger modulus only while swallows remain, so swallow zero gives P alone
	assign use_large   = !fixed_mode && (swallowed < swallow_count);
	assign modulus     = presc_base(feedback_prescaler_mode) + {5'h00, use_large};
	// Bypass ignored in dual modulus; a zero count is treated as one
	assign main_eff    = ((fixed_mode && fbctrl[`MAIN_BYPASS_BIT]) || (main_count == 13'h0000))
	                     ? 13'h0001 : main_count;
	// At-or-above ends a count left long by reprogramming, instead of a full wrap
	assign presc_done  = vco_rise && (presc_cnt >= modulus - 6'h01);
	assign period_done = presc_done && (cycle_cnt >= main_eff - 13'h0001);

	// Prescaler counter steps on each synchronised VCO rising edge; swallow and main counters step on its terminal count
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			presc_cnt     <= 6'h00;
			cycle_cnt     <= 13'h0000;
			swallowed     <= 6'h00;
			presc_pulse   <= 1'b0;
			swallow_pulse <= 1'b0;
			n_pulse       <= 1'b0;
			n_delayed     <= 1'b0;
		end else if (ce_in) begin
			presc_pulse   <= presc_done;
			n_pulse       <= period_done;
			n_delayed     <= n_pulse;         // Delay stage ahead of the selector
			swallow_pulse <= 1'b0;
			if (hold_ab) begin
				presc_cnt <= 6'h00;
				cycle_cnt <= 13'h0000;
				swallowed <= 6'h00;
			end else if (vco_rise) begin
				if (presc_done) begin
					presc_cnt <= 6'h00;
					if (period_done) begin
						cycle_cnt <= 13'h0000;
						swallowed <= 6'h00;
					end else begin
						cycle_cnt <= cycle_cnt + 13'h0001;
						if (use_large) begin
							swallowed     <= swallowed + 6'h01;
							swallow_pulse <= (swallowed + 6'h01 == swallow_count);
						end
					end
				end else begin
					presc_cnt <= presc_cnt + 6'h01;
				end
			end
		end
	end

	//********************************************************************
	// Reference divider
	//********************************************************************

	reg  [13:0] ref_cnt;
	reg         r_pulse;
	reg         r_delayed;
	wire [13:0] r_eff;
	assign r_eff = (r_count == 14'h0000) ? 14'h0001 : r_count;

	// Counts selected-reference rising edges; held cleared by the R-reset and reset-all controls
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			ref_cnt   <= 14'h0000;
			r_pulse   <= 1'b0;
			r_delayed <= 1'b0;
		end else if (ce_in) begin
			r_delayed <= r_pulse;
			r_pulse   <= 1'b0;
			if (hold_r) begin
				ref_cnt <= 14'h0000;
			end else if (ref_rise) begin
				if (ref_cnt == r_eff - 14'h0001) begin
					ref_cnt <= 14'h0000;
					r_pulse <= 1'b1;
				end else begin
					ref_cnt <= ref_cnt + 14'h0001;
				end
			end
		end
	end

	//********************************************************************
	// Pin selectors
	//********************************************************************

	// All outputs registered so the pins never glitch on a selector change
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			feedback_out              <= 1'b0;
			status_pin_out            <= 1'b0;
			reference_monitor_pin_out <= 1'b0;
			lock_detect_pin_out       <= 1'b0;
		end else if (ce_in) begin
			feedback_out   <= n_delayed;
			status_pin_out <= sel_bit(status_code, n_delayed, r_delayed, swallow_pulse,
				presc_pulse, phase_detector_up_in, phase_detector_down_in, first_ref_sync[2],
				second_ref_sync[2], second_ref_selected_in, diff_ref_mode_in);
			// Monitor and lock pins reach only the upper half of the table
			reference_monitor_pin_out <= sel_bit({1'b1, reference_monitor_sel_in}, n_delayed,
				r_delayed, swallow_pulse, presc_pulse, phase_detector_up_in,
				phase_detector_down_in, first_ref_sync[2], second_ref_sync[2],
				second_ref_selected_in, diff_ref_mode_in);
			lock_detect_pin_out <= sel_bit({1'b1, lock_detect_sel_in}, n_delayed, r_delayed,
				swallow_pulse, presc_pulse, phase_detector_up_in, phase_detector_down_in,
				first_ref_sync[2], second_ref_sync[2], second_ref_selected_in,
				diff_ref_mode_in);
		end
	end

endmodule

//--- sim/pll_status_sva.sv
// Concurrent checks on selector routing, selector readback and feedback pulse shape
`timescale 1ns/1ps
`include "pll_fbdiv_defs.vh"
module pll_status_sva #(
	parameter ADDR_W = 10,
	parameter DATA_W = 8
) (
	input wire logic              clk_in,
	input wire logic              rst_b_in,
	input wire logic              ce_in,
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic              reg_wr_in,
	input wire logic [DATA_W-1:0] reg_rdata_out,
	input wire logic              phase_detector_up_in,
	input wire logic              phase_detector_down_in,
	input wire logic [4:0]        reference_monitor_sel_in,
	input wire logic [4:0]        lock_detect_sel_in,
	input wire logic              feedback_out,
	input wire logic              status_pin_out,
	input wire logic              reference_monitor_pin_out,
	input wire logic              lock_detect_pin_out
);
	logic [DATA_W-1:0] sel_byte;
	logic              lock_bit;
	wire  [5:0]        sel_q = sel_byte[7:2];
	// Shadow of the selector byte; a locked write must leave it alone
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			sel_byte <= 8'h00;
			lock_bit <= 1'b0;
		end else if (ce_in && reg_wr_in) begin
			if (reg_addr_in == `EEPROM_CTRL_ADDR)
				lock_bit <= reg_wdata_in[`EEPROM_LOCK_BIT];
			if (reg_addr_in == `STATUS_SEL_ADDR && !lock_bit)
				sel_byte <= reg_wdata_in;
		end
	end
	// A frozen clock enable stalls every flop, so checks pause with it
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in || !ce_in);
	sequence s_pulse;
		feedback_out ##1 !feedback_out;
	endsequence
	sequence s_low_unused;
		!sel_q[5] && (sel_q == `SEL_GROUND || sel_q > `SEL_PD_DOWN);
	endsequence
	chk_pd_up_route: assert property (
		sel_q == `SEL_PD_UP |=> status_pin_out == $past(phase_detector_up_in))
		else $error("status pin does not follow up pulse");
	chk_pd_down_route: assert property (
		sel_q == `SEL_PD_DOWN |=> status_pin_out == $past(phase_detector_down_in))
		else $error("status pin does not follow down pulse");
	chk_low_ground: assert property (s_low_unused |=> !status_pin_out)
		else $error("unused low selector code not grounded");
	chk_high_ground: assert property (sel_q == `SEL_GROUND_HI |=> !status_pin_out)
		else $error("top half ground code not grounded");
	chk_monitor_ground: assert property (
		reference_monitor_sel_in == 5'h00 |=> !reference_monitor_pin_out)
		else $error("monitor pin not grounded");
	chk_lock_ground: assert property (
		lock_detect_sel_in == 5'h00 |=> !lock_detect_pin_out)
		else $error("lock pin not grounded");
	chk_sel_readback: assert property (
		reg_addr_in == `STATUS_SEL_ADDR |=> reg_rdata_out == $past(sel_byte))
		else $error("selector readback mismatch");
	chk_fb_pulse_width: assert property ($rose(feedback_out) |-> s_pulse)
		else $error("feedback pulse not one cycle wide");
	chk_ndiv_route: assert property (
		$past(sel_q) == `SEL_NDIV |-> status_pin_out == feedback_out)
		else $error("status pin does not follow feedback output");
endmodule
bind pll_prescaler_and_status_select pll_status_sva #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_sva (
	.clk_in(clk_in), .rst_b_in(rst_b_in), .ce_in(ce_in), .reg_addr_in(reg_addr_in),
	.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out),
	.phase_detector_up_in(phase_detector_up_in),
	.phase_detector_down_in(phase_detector_down_in),
	.reference_monitor_sel_in(reference_monitor_sel_in),
	.lock_detect_sel_in(lock_detect_sel_in), .feedback_out(feedback_out),
	.status_pin_out(status_pin_out), .reference_monitor_pin_out(reference_monitor_pin_out),
	.lock_detect_pin_out(lock_detect_pin_out));

//--- sim/tb.sv
// Self-checking bench for the prescaler and status selector block
`timescale 1ns/1ps
`include "pll_fbdiv_defs.vh"
module tb;
	logic       clk_in, rst_b_in, ce_in, reg_wr_in, vco_clk_in, status_pin_out;
	logic       first_reference_clock_in, second_reference_clock_in, diff_ref_mode_in;
	logic       second_ref_selected_in, phase_detector_up_in, phase_detector_down_in;
	logic       feedback_out, reference_monitor_pin_out, lock_detect_pin_out;
	logic [9:0] reg_addr_in;
	logic [7:0] reg_wdata_in, reg_rdata_out;
	logic [4:0] reference_monitor_sel_in, lock_detect_sel_in;
	int         err_total, checked, seed;
	pll_prescaler_and_status_select u_dut (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.ce_in(ce_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in), .reg_rdata_out(reg_rdata_out), .vco_clk_in(vco_clk_in),
		.first_reference_clock_in(first_reference_clock_in),
		.second_reference_clock_in(second_reference_clock_in),
		.diff_ref_mode_in(diff_ref_mode_in),
		.second_ref_selected_in(second_ref_selected_in),
		.phase_detector_up_in(phase_detector_up_in),
		.phase_detector_down_in(phase_detector_down_in),
		.reference_monitor_sel_in(reference_monitor_sel_in),
		.lock_detect_sel_in(lock_detect_sel_in), .feedback_out(feedback_out),
		.status_pin_out(status_pin_out), .reference_monitor_pin_out(reference_monitor_pin_out),
		.lock_detect_pin_out(lock_detect_pin_out));
	// ****************************************
	// Clock, feedback clock and watchdog
	// ****************************************
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	// Feedback clock toggles every two cycles, a period of four clocks
	initial begin
		vco_clk_in = 1'b0;
		forever begin
			repeat (2) @(posedge clk_in);
			#1 vco_clk_in = ~vco_clk_in;
		end
	end
	initial begin
		#200000;
		err_total++;
		$display("Error watchdog expired");
		print_verdict();
	end
	// ****************************************
	// Tasks and expectations
	// ****************************************
	task automatic print_verdict();
		$display("Checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk_val(input string n, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic chk_cnt(input string n, input int e, input int g);
		checked++;
		if (g != e) begin
			err_total++;
			$display("Error %s expected %0d seen %0d", n, e, g);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_in);
		#1;
		reg_addr_in = a;
		reg_wdata_in = d;
		reg_wr_in = 1'b1;
		@(posedge clk_in);
		#1;
		reg_wr_in = 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] e);
		@(posedge clk_in);
		#1;
		reg_addr_in = a;
		@(posedge clk_in);
		#1;
		chk_val($sformatf("reg %h", a), e, reg_rdata_out);
	endtask
	// Bounded wait for the next feedback pulse, returning the cycles spent
	task automatic wait_fb(output int n);
		n = 0;
		do begin
			@(posedge clk_in);
			#1;
			n++;
		end while (feedback_out !== 1'b1 && n < 4000);
	endtask
	function automatic int exp_edges(input int m, input int a, input int b, input bit byp);
		int p;
		p = (m == 0) ? 1 : (m == 7) ? 3 : (m == 1) ? 2 : (1 << (m - 1));
		if (m < 2 || m == 7)
			return byp ? p : p * b;
		return (p + 1) * a + p * (b - a);
	endfunction
	function automatic logic exp_pin(input logic [5:0] c, input logic [5:0] s);
		logic r1, r2, s2, d;
		{r1, r2, s2, d} = s[5:2];
		case (c)
			`SEL_PD_UP: return s[1];
			`SEL_PD_DOWN: return s[0];
			`SEL_FIRST_REF: return r1;
			`SEL_SECOND_REF: return d ? 1'b0 : r2;
			`SEL_REF_SELECTED: return d ? r1 : (s2 ? r2 : r1);
			`SEL_REF_UNSEL: return d ? 1'b0 : (s2 ? r1 : r2);
			default: return 1'b0;
		endcase
	endfunction
	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		logic [5:0]  codes [12] = '{6'h00, 6'h05, 6'h06, 6'h07, 6'h08, 6'h10, 6'h1f, 6'h20,
			6'h21, 6'h22, 6'h23, 6'h24};
		logic [9:0]  ra [9] = '{10'h011, 10'h012, 10'h013, 10'h014, 10'h015, 10'h016,
			10'h017, 10'h01d, 10'h3ff};
		logic [7:0]  rv [9] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h06, 8'h00, 8'h00, 8'h00};
		logic [5:0]  c, s;
		logic [31:0] r;
		int          a, b, n;
		bit          byp;
		seed = 75;
		{rst_b_in, reg_wr_in, reg_addr_in, reg_wdata_in} = '0;
		{first_reference_clock_in, second_reference_clock_in, second_ref_selected_in} = '0;
		{diff_ref_mode_in, phase_detector_up_in, phase_detector_down_in} = '0;
		{reference_monitor_sel_in, lock_detect_sel_in} = '0;
		ce_in = 1'b1;
		repeat (5) @(posedge clk_in);
		#1 rst_b_in = 1'b1;
		for (int i = 0; i < 9; i++)
			rd(ra[i], rv[i]);
		$display("Test reset_values done");
		// Selector codes across random reference and pulse input levels
		for (int i = 0; i < 36; i++) begin
			r = $random(seed);
			c = codes[i < 12 ? i : r[15:8] % 12];
			s = r[5:0];
			wr(`STATUS_SEL_ADDR, {c, 2'b00});
			{first_reference_clock_in, second_reference_clock_in, second_ref_selected_in} = s[5:3];
			{diff_ref_mode_in, phase_detector_up_in, phase_detector_down_in} = s[2:0];
			reference_monitor_sel_in = c[4:0];
			lock_detect_sel_in = c[4:0];
			repeat (6) @(posedge clk_in);
			#1;
			chk_val("status", {7'h0, exp_pin(c, s)}, {7'h0, status_pin_out});
			if (c[5]) begin
				chk_val("monitor", {7'h0, exp_pin(c, s)}, {7'h0, reference_monitor_pin_out});
				chk_val("lock", {7'h0, exp_pin(c, s)}, {7'h0, lock_detect_pin_out});
			end
		end
		$display("Test selector_codes done");
		// A locked selector ignores writes until the lock bit is cleared
		wr(`STATUS_SEL_ADDR, 8'h90);
		wr(`EEPROM_CTRL_ADDR, 8'h80);
		wr(`STATUS_SEL_ADDR, 8'h14);
		rd(`STATUS_SEL_ADDR, 8'h90);
		wr(`EEPROM_CTRL_ADDR, 8'h00);
		wr(`STATUS_SEL_ADDR, 8'h14);
		rd(`STATUS_SEL_ADDR, 8'h14);
		$display("Test selector_lock done");
		// Route the delayed feedback output to the status pin while periods run
		wr(`STATUS_SEL_ADDR, 8'h04);
		// Feedback period for every prescaler code, swallow zero included
		for (int m = 0; m < 8; m++) begin
			r = $random(seed);
			a = (m == 3) ? 0 : 1 + r[1:0];
			b = 4 + r[3:2];
			byp = (m == 1 || m == 6) ? 1'b1 : r[4];
			wr(`SWALLOW_ADDR, a[7:0]);
			wr(`MAIN_LSB_ADDR, b[7:0]);
			wr(`MAIN_MSB_ADDR, 8'h00);
			wr(`FBCTRL_ADDR, {4'h0, byp, m[2:0]});
			wait_fb(n);
			wait_fb(n);
			wait_fb(n);
			chk_cnt($sformatf("period m%0d", m), 4 * exp_edges(m, a, b, byp), n);
		end
		$display("Test feedback_period done");
		print_verdict();
	end
endmodule
